//--- src/pin_state_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "pin_state_params.svh"

module pin_state_ctrl
(
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_ce,
    input  wire logic [3:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    input  wire logic [1:0] i_mode,
    input  wire logic [7:0] i_periph_oe,
    input  wire logic [7:0] i_periph_out,
    input  wire logic       i_touch_dout,
    input  wire logic       i_beep,
    input  wire logic       i_cmp_result,
    input  wire logic       i_sense_clk,
    input  wire logic       i_cmp_analog,
    input  wire logic       i_touch_det,
    input  wire logic       i_rst_pad_n,
    input  wire logic [7:0] i_pad_in,
    output logic      [7:0] o_pad_out,
    output logic      [7:0] o_pad_oe_n,
    output logic      [7:0] o_pad_ie,
    output logic      [7:0] o_pad_pu,
    output logic      [7:0] o_port_in,
    output logic      [7:0] o_xint_in,
    output logic            o_ext_rst_req,
    output logic            o_irq
);

    ////////////////////////////////////////////////////////////////////////

    function automatic logic is_standby(input logic [1:0] mode);
        is_standby = (mode == pin_state_pkg::MODE_STOP) ||
                     (mode == pin_state_pkg::MODE_WATCH);
    endfunction : is_standby

    function automatic logic rising(input logic now, input logic was);
        rising = now & ~was;
    endfunction : rising

    function automatic logic addr_hit(input logic       strobe,
                                      input logic [3:0] addr,
                                      input logic [3:0] target);
        addr_hit = strobe && (addr == target);
    endfunction : addr_hit

    ////////////////////////////////////////////////////////////////////////

    pin_state_pkg::core_state_t state_reg;
    pin_state_pkg::core_state_t state_next;

    logic [7:0] pad_sync;
    logic [2:0] misc_sync;
    logic       cmp_sync;
    logic       touch_sync;
    logic       rst_pad_low_sync;
    logic [7:0] normal_drv;
    logic [7:0] normal_out;
    logic [7:0] drv;
    logic [7:0] out;
    logic [7:0] ie;
    logic [7:0] events;
    logic       standby;

    irq_if irq_bus();

    sync2 #(.WIDTH(8)) pad_sync_u
    (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_ce    (i_ce),
        .i_async (i_pad_in),
        .o_sync  (pad_sync)
    );

    // The reset pad is inverted ahead of its synchroniser, so that cleared
    // flops mean no request and no false request follows a reset.
    sync2 #(.WIDTH(3)) misc_sync_u
    (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_ce    (i_ce),
        .i_async ({~i_rst_pad_n, i_touch_det, i_cmp_analog}),
        .o_sync  (misc_sync)
    );

    assign cmp_sync         = misc_sync[0];
    assign touch_sync       = misc_sync[1];
    assign rst_pad_low_sync = misc_sync[2];

    irq_unit irq_u
    (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_ce  (i_ce),
        .bus   (irq_bus.unit)
    );

    ////////////////////////////////////////////////////////////////////////

    assign standby    = is_standby(i_mode);
    assign normal_drv = i_periph_oe | state_reg.direction;
    assign normal_out = (i_periph_oe & i_periph_out) |
                        (~i_periph_oe & state_reg.out_latch);

    // Pad drive, value and input gate for the present phase.
    always_comb
    begin
        drv = '0;
        out = '0;
        ie  = '0;
        case (state_reg.phase)
            pin_state_pkg::PH_ACTIVE:
            begin
                drv = normal_drv;
                out = normal_out;
                ie  = `ALL_ONES8;
            end
            pin_state_pkg::PH_HOLD:
            begin
                drv = state_reg.held_drv;
                out = state_reg.held_out;
                if (state_reg.func_ctrl[`FN_BEEP_OUT])
                begin
                    drv[`PIN_TOUCH_DOUT] = 1'b1;
                    out[`PIN_TOUCH_DOUT] = i_beep;
                end
                else if (state_reg.func_ctrl[`FN_TOUCH_DOUT])
                begin
                    drv[`PIN_TOUCH_DOUT] = 1'b1;
                    out[`PIN_TOUCH_DOUT] = i_touch_dout;
                end
                if (state_reg.func_ctrl[`FN_CMP_OUT])
                begin
                    drv[`PIN_CMP_OUT] = 1'b1;
                    out[`PIN_CMP_OUT] = i_cmp_result;
                end
                ie = '0;
            end
            pin_state_pkg::PH_FLOAT:
            begin
                drv = '0;
                out = '0;
                ie  = '0;
            end
            default:
            begin
                drv = '0;
                out = '0;
                ie  = '0;
            end
        endcase
        if ((state_reg.phase != pin_state_pkg::PH_ACTIVE) &&
            state_reg.func_ctrl[`FN_TSC_RUN])
        begin
            drv = drv | `MASK_TOUCH;
            out = (out & ~`MASK_TOUCH) |
                  ({8{i_sense_clk}} & `MASK_TOUCH);
        end
    end

    ////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        state_next = state_reg;
        events     = '0;

        // Entry into stop or watch samples the hold bit and the drive.
        if (!standby)
        begin
            state_next.phase = pin_state_pkg::PH_ACTIVE;
        end
        else if (state_reg.phase == pin_state_pkg::PH_ACTIVE)
        begin
            state_next.held_out = normal_out;
            state_next.held_drv = normal_drv;
            if (state_reg.pin_hold)
            begin
                state_next.phase = pin_state_pkg::PH_FLOAT;
            end
            else
            begin
                state_next.phase = pin_state_pkg::PH_HOLD;
            end
        end

        // Pads are registered, so they follow the phase one edge later.
        state_next.pad_out  = out;
        state_next.pad_oe_n = ~drv;
        state_next.pad_ie   = ie;
        // Pull-up drops only while the pad itself drives low.
        state_next.pad_pu   = state_reg.pull_up & ~(drv & ~out);

        state_next.port_in   = pad_sync & state_reg.pad_ie;
        state_next.xint_path = pad_sync & `MASK_XINT &
                               state_reg.xint_en;
        state_next.cmp_d     = cmp_sync;
        state_next.touch_d   = touch_sync;
        state_next.ext_rst_req = state_reg.func_ctrl[`FN_RESET_PIN] &
                                 rst_pad_low_sync;

        // Either edge of an enabled external interrupt path is an event.
        events[`IRQ_XINT]  = |(state_reg.xint_path &
                               ~state_next.xint_path);
        events[`IRQ_XINT]  = events[`IRQ_XINT] |
                             (|(state_next.xint_path &
                                ~state_reg.xint_path));
        events[`IRQ_CMP]   = rising(cmp_sync, state_reg.cmp_d) &
                             state_reg.func_ctrl[`FN_CMP_IRQ_EN];
        events[`IRQ_TOUCH] = rising(touch_sync, state_reg.touch_d) &
                             state_reg.func_ctrl[`FN_TOUCH_IRQ_EN];

        // Read-only and unmapped addresses take no write here.
        if (i_wr)
        begin
            case (i_addr)
                `ADDR_STBY_CTRL:
                begin
                    state_next.pin_hold = i_wdata[`BIT_PIN_HOLD];
                end
                `ADDR_DIRECTION:
                begin
                    state_next.direction = i_wdata;
                end
                `ADDR_OUT_LATCH:
                begin
                    state_next.out_latch = i_wdata;
                end
                `ADDR_PULL_UP:
                begin
                    state_next.pull_up = i_wdata;
                end
                `ADDR_FUNC_CTRL:
                begin
                    state_next.func_ctrl = i_wdata;
                end
                `ADDR_XINT_EN:
                begin
                    state_next.xint_en = i_wdata;
                end
                default:
                begin
                    state_next.xint_en = state_reg.xint_en;
                end
            endcase
        end

        // Read data stand for one cycle and are zero otherwise.
        state_next.rdata = '0;
        if (i_rd)
        begin
            case (i_addr)
                `ADDR_STBY_CTRL:
                begin
                    state_next.rdata = {7'h00, state_reg.pin_hold};
                end
                `ADDR_DIRECTION:
                begin
                    state_next.rdata = state_reg.direction;
                end
                `ADDR_OUT_LATCH:
                begin
                    state_next.rdata = state_reg.out_latch;
                end
                `ADDR_PULL_UP:
                begin
                    state_next.rdata = state_reg.pull_up;
                end
                `ADDR_FUNC_CTRL:
                begin
                    state_next.rdata = state_reg.func_ctrl;
                end
                `ADDR_XINT_EN:
                begin
                    state_next.rdata = state_reg.xint_en;
                end
                `ADDR_PORT_IN:
                begin
                    state_next.rdata = state_reg.port_in;
                end
                `ADDR_IRQ_STATUS:
                begin
                    state_next.rdata = irq_bus.status;
                end
                `ADDR_IRQ_ENABLE:
                begin
                    state_next.rdata = irq_bus.enable;
                end
                default:
                begin
                    state_next.rdata = '0;
                end
            endcase
        end
    end

    // Clear and enable writes reach the status unit as one-cycle strobes.
    assign irq_bus.events    = events;
    assign irq_bus.clear_wr  = addr_hit(i_wr, i_addr, `ADDR_IRQ_CLEAR);
    assign irq_bus.enable_wr = addr_hit(i_wr, i_addr, `ADDR_IRQ_ENABLE);
    assign irq_bus.wdata     = i_wdata;

    ////////////////////////////////////////////////////////////////////////

    // Reset floats every pad; only analog and touch pads block input.
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_reg           <= '0;
            state_reg.func_ctrl <= `RST_FUNC_CTRL;
            state_reg.pad_oe_n  <= `ALL_ONES8;
            state_reg.pad_ie    <= ~`MASK_ANALOG;
            state_reg.phase     <= pin_state_pkg::PH_ACTIVE;
        end
        else if (i_ce)
        begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////

    assign o_rdata       = state_reg.rdata;
    assign o_pad_out     = state_reg.pad_out;
    assign o_pad_oe_n    = state_reg.pad_oe_n;
    assign o_pad_ie      = state_reg.pad_ie;
    assign o_pad_pu      = state_reg.pad_pu;
    assign o_port_in     = state_reg.port_in;
    assign o_xint_in     = state_reg.xint_path;
    assign o_ext_rst_req = state_reg.ext_rst_req;
    assign o_irq         = irq_bus.irq;

endmodule : pin_state_ctrl

`default_nettype wire

//--- src/pin_state_params.svh
// Summary of operation
// - Hold bit one: standby pins float, input blocked
// - Hold bit zero: standby pins keep previous drive
// - Blocked input gate hides pad level internally
// - Enabled external interrupt passes despite blocking
// - Comparator analog input still raises its interrupt
// - Touch signal still raises enabled touch interrupt
// - Touch direct output only if hold zero, enabled
// - Beep output only if hold zero, enabled
// - Comparator output only if hold zero, enabled
// - Running touch controller drives sensing clock on pins
// - Pull-up setting stays active while floating
// - Reset: digital pins float, input gate enabled
// - Reset: analog or touch pins float, gate blocked
// - Reset pin stays reset input in every mode
// - Hold bit one floats pad despite direction
// - Blocked input reads as low internally
`ifndef PIN_STATE_PARAMS_SVH
`define PIN_STATE_PARAMS_SVH

`define ADDR_STBY_CTRL   4'h0
`define ADDR_DIRECTION   4'h1
`define ADDR_OUT_LATCH   4'h2
`define ADDR_PULL_UP     4'h3
`define ADDR_FUNC_CTRL   4'h4
`define ADDR_XINT_EN     4'h5
`define ADDR_PORT_IN     4'h6
`define ADDR_IRQ_STATUS  4'h7
`define ADDR_IRQ_CLEAR   4'h8
`define ADDR_IRQ_ENABLE  4'h9

`define BIT_PIN_HOLD     0

`define FN_TOUCH_DOUT    0
`define FN_BEEP_OUT      1
`define FN_CMP_OUT       2
`define FN_TSC_RUN       3
`define FN_CMP_IRQ_EN    4
`define FN_TOUCH_IRQ_EN  5
`define FN_RESET_PIN     6

`define PIN_TOUCH_DOUT   0
`define PIN_CMP_OUT      2

`define MASK_ANALOG      8'hCF
`define MASK_XINT        8'h32
`define MASK_TOUCH       8'hC0

`define IRQ_XINT         0
`define IRQ_CMP          1
`define IRQ_TOUCH        2

`define RST_FUNC_CTRL    8'h40
`define RST_ZERO8        8'h00
`define ALL_ONES8        8'hFF

`endif

//--- src/pin_state_pkg.sv
package pin_state_pkg;

    typedef enum logic [1:0]
    {
        MODE_RUN   = 2'b00,
        MODE_SLEEP = 2'b01,
        MODE_STOP  = 2'b10,
        MODE_WATCH = 2'b11
    } power_mode_t;

    typedef enum logic [1:0]
    {
        PH_ACTIVE = 2'b00,
        PH_HOLD   = 2'b01,
        PH_FLOAT  = 2'b10
    } pad_phase_t;

    typedef struct packed
    {
        logic       pin_hold;
        logic [7:0] direction;
        logic [7:0] out_latch;
        logic [7:0] pull_up;
        logic [7:0] func_ctrl;
        logic [7:0] xint_en;
        pad_phase_t phase;
        logic [7:0] held_out;
        logic [7:0] held_drv;
        logic [7:0] pad_out;
        logic [7:0] pad_oe_n;
        logic [7:0] pad_ie;
        logic [7:0] pad_pu;
        logic [7:0] port_in;
        logic [7:0] xint_path;
        logic       cmp_d;
        logic       touch_d;
        logic       ext_rst_req;
        logic [7:0] rdata;
    } core_state_t;

    typedef struct packed
    {
        logic [7:0] status;
        logic [7:0] enable;
        logic       irq;
    } irq_state_t;

endpackage : pin_state_pkg

//--- src/irq_if.sv
`timescale 1ns/1ps
`default_nettype none

interface irq_if;
    logic [7:0] events;
    logic       clear_wr;
    logic       enable_wr;
    logic [7:0] wdata;
    logic [7:0] status;
    logic [7:0] enable;
    logic       irq;

    modport unit
    (
        input  events,
        input  clear_wr,
        input  enable_wr,
        input  wdata,
        output status,
        output enable,
        output irq
    );

    modport core
    (
        output events,
        output clear_wr,
        output enable_wr,
        output wdata,
        input  status,
        input  enable,
        input  irq
    );
endinterface : irq_if

`default_nettype wire

//--- src/sync2.sv
`timescale 1ns/1ps
`default_nettype none

module sync2
#(
    parameter int WIDTH = 8
)
(
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic             i_ce,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
        end
        else if (i_ce)
        begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;

endmodule : sync2

`default_nettype wire

//--- src/irq_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "pin_state_params.svh"

module irq_unit
(
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_ce,
    irq_if.unit       bus
);

    pin_state_pkg::irq_state_t state_reg;
    pin_state_pkg::irq_state_t state_next;

    // A new event in the same cycle as its clear keeps the bit set.
    always_comb
    begin
        state_next = state_reg;
        if (bus.clear_wr)
        begin
            state_next.status = state_reg.status & ~bus.wdata;
        end
        state_next.status = state_next.status | bus.events;
        if (bus.enable_wr)
        begin
            state_next.enable = bus.wdata;
        end
        state_next.irq = |(state_next.status & state_next.enable);
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_reg <= '0;
        end
        else if (i_ce)
        begin
            state_reg <= state_next;
        end
    end

    assign bus.status = state_reg.status;
    assign bus.enable = state_reg.enable;
    assign bus.irq    = state_reg.irq;

endmodule : irq_unit

`default_nettype wire

//--- testbench/board_model.sv
`timescale 1ns/1ps
`default_nettype none

module board_model
(
    input  wire logic       i_clk,
    input  wire logic [7:0] i_pad_out,
    input  wire logic [7:0] i_pad_oe_n,
    input  wire logic [7:0] i_pad_pu,
    input  wire logic [7:0] i_drv_en,
    input  wire logic [7:0] i_drv_val,
    output logic      [7:0] o_pad_in
);
    logic [7:0] float_reg = 8'h00;

    // An undriven line without pull-up wanders, so it toggles at every rising clock edge.
    always_ff @(posedge i_clk)
        float_reg <= ~float_reg;

    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (i_drv_en[i])
                o_pad_in[i] = i_drv_val[i];
            else if (!i_pad_oe_n[i])
                o_pad_in[i] = i_pad_out[i];
            else if (i_pad_pu[i])
                o_pad_in[i] = 1'b1;
            else
                o_pad_in[i] = float_reg[i];
        end
    end
endmodule : board_model

`default_nettype wire

//--- testbench/pin_state_properties.sv
`timescale 1ns/1ps
`default_nettype none

module pin_state_properties
(
    input wire logic       i_clk,
    input wire logic       i_rst,
    input wire logic       i_ce,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic [1:0] i_mode,
    input wire logic       i_cmp_result,
    input wire logic       i_sense_clk,
    input wire logic       i_rst_pad_n,
    input wire logic [7:0] o_pad_out,
    input wire logic [7:0] o_pad_oe_n,
    input wire logic [7:0] o_pad_ie,
    input wire logic [7:0] o_pad_pu,
    input wire logic [7:0] o_port_in,
    input wire logic       o_ext_rst_req
);
    logic       hold_reg;
    logic [7:0] func_reg;
    logic [7:0] pull_reg;
    logic       wr_ok;

    assign wr_ok = i_ce && i_wr;

    // Settings are mirrored from the register writes.
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            hold_reg <= 1'b0;
            func_reg <= 8'h40;
            pull_reg <= 8'h00;
        end
        else
        begin
            hold_reg <= (wr_ok && i_addr == 4'h0) ? i_wdata[0] : hold_reg;
            func_reg <= (wr_ok && i_addr == 4'h4) ? i_wdata : func_reg;
            pull_reg <= (wr_ok && i_addr == 4'h3) ? i_wdata : pull_reg;
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    // Standby long enough for the pad phase to have settled.
    sequence s_stby;
        (i_ce && i_mode[1])[*4];
    endsequence
    sequence s_deep;
        s_stby ##1 (i_ce && i_mode[1]);
    endsequence

    float_pins_a: assert property (
        s_stby ##0 hold_reg |-> o_pad_oe_n[5:0] == 6'h3F)
        else $error("pads driven in float");
    input_gate_a: assert property (s_stby |-> o_pad_ie == 8'h00)
        else $error("input gate open in standby");
    input_low_a: assert property (s_deep |-> o_port_in == 8'h00)
        else $error("blocked input not low");
    hold_drive_a: assert property (
        s_deep ##0 !hold_reg
        |-> $stable({o_pad_oe_n[5:3], o_pad_oe_n[1]}))
        else $error("held drive changed");
    cmp_out_a: assert property (
        s_stby ##0 (!hold_reg && func_reg[2])
        |-> !o_pad_oe_n[2] && o_pad_out[2] == $past(i_cmp_result))
        else $error("comparator pin wrong");
    sense_clk_a: assert property (
        s_stby ##0 func_reg[3] |-> o_pad_oe_n[7:6] == 2'b00
        && o_pad_out[7:6] == {2{$past(i_sense_clk)}})
        else $error("sensing clock missing");
    pull_kept_a: assert property (
        s_stby ##0 hold_reg |-> o_pad_pu[5:0] == pull_reg[5:0])
        else $error("pull-up lost in float");
    reset_pads_a: assert property (disable iff (1'b0)
        i_rst && $past(i_rst) |-> o_pad_oe_n == 8'hFF && o_pad_ie == 8'h30)
        else $error("pads wrong in reset");
    rst_pin_on_a: assert property (
        (!i_rst_pad_n && func_reg[6])[*4] |-> o_ext_rst_req)
        else $error("reset pin ignored");
    rst_pin_off_a: assert property (
        (i_rst_pad_n || !func_reg[6])[*4] |-> !o_ext_rst_req)
        else $error("false reset request");
    awake_gate_a: assert property (
        (i_ce && !i_mode[1])[*4] |-> o_pad_ie == 8'hFF)
        else $error("input gate shut while awake");
endmodule : pin_state_properties

`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic       i_clk = 1'b0, i_rst = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
    logic       i_beep = 1'b0, i_touch_dout = 1'b0, i_cmp_result = 1'b0;
    logic       i_sense_clk = 1'b0, i_cmp_analog = 1'b0, i_touch_det = 1'b0;
    logic       i_rst_pad_n = 1'b1, o_ext_rst_req, o_irq;
    logic [1:0] i_mode = 2'b00;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wdata = 8'h00, i_periph_oe = 8'h00, i_periph_out = 8'hFF;
    logic [7:0] drv_en = 8'hFF, drv_val = 8'hA0, i_pad_in, o_rdata;
    logic [7:0] o_pad_out, o_pad_oe_n, o_pad_ie, o_pad_pu, o_port_in;
    logic [7:0] o_xint_in;
    int         fails = 0;
    int         samples_checked = 0;

    always #5 i_clk = ~i_clk;
    always @(posedge i_clk) i_sense_clk <= ~i_sense_clk;

    pin_state_ctrl dut (.i_clk, .i_rst, .i_ce(1'b1), .i_addr, .i_wdata,
        .i_wr, .i_rd, .o_rdata, .i_mode, .i_periph_oe,
        .i_periph_out, .i_touch_dout, .i_beep, .i_cmp_result,
        .i_sense_clk, .i_cmp_analog, .i_touch_det, .i_rst_pad_n, .i_pad_in,
        .o_pad_out, .o_pad_oe_n, .o_pad_ie, .o_pad_pu, .o_port_in,
        .o_xint_in, .o_ext_rst_req, .o_irq);

    board_model board (.i_clk, .i_pad_out(o_pad_out),
        .i_pad_oe_n(o_pad_oe_n), .i_pad_pu(o_pad_pu), .i_drv_en(drv_en),
        .i_drv_val(drv_val), .o_pad_in(i_pad_in));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                     exp);
        end
    endtask : chk

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    task automatic lk(input int n);
        repeat (n) @(posedge i_clk);
        @(negedge i_clk);
    endtask : lk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        chk(o_rdata, exp);
    endtask : rd

    task automatic go(input logic [1:0] m);
        @(posedge i_clk);
        i_mode <= m;
        lk(5);
    endtask : go

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        i_rst <= 1'b1;
        @(negedge i_clk);
        chk(o_pad_oe_n, 8'hFF);
        chk(o_pad_ie, 8'h30);
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        rd(4'h4, 8'h40);
        rd(4'hF, 8'h00);
    endtask : t_reset

    task automatic t_sleep();
        wr(4'h1, 8'h0F);
        wr(4'h2, 8'h05);
        wr(4'h3, 8'hFF);
        drv_en <= 8'hF0;
        @(posedge i_clk);
        i_mode <= 2'b01;
        i_periph_oe <= 8'h10;
        lk(5);
        chk(o_pad_oe_n, 8'hE0);
        chk(o_pad_ie, 8'hFF);
        chk(o_port_in, 8'hA5);
        chk(o_pad_out, 8'h15);
        wr(4'h6, 8'h00);
        rd(4'h6, 8'hA5);
        @(posedge i_clk);
        i_periph_oe <= 8'h00;
        go(2'b00);
    endtask : t_sleep

    task automatic t_float();
        wr(4'h4, 8'h47);
        wr(4'h0, 8'h01);
        go(2'b10);
        chk(o_pad_oe_n, 8'hFF);
        chk(o_pad_ie, 8'h00);
        chk(o_port_in, 8'h00);
        chk(o_pad_pu, 8'hFF);
        go(2'b00);
        chk(o_pad_ie, 8'hFF);
    endtask : t_float

    task automatic t_hold();
        wr(4'h0, 8'h00);
        i_beep <= 1'b1;
        go(2'b11);
        chk(o_pad_oe_n, 8'hF0);
        chk(o_pad_ie, 8'h00);
        chk({4'h0, o_pad_out[3:0]}, 8'h01);
        @(posedge i_clk);
        i_cmp_result <= 1'b1;
        i_touch_dout <= 1'b1;
        wr(4'h4, 8'h45);
        lk(2);
        chk({4'h0, o_pad_out[3:0]}, 8'h05);
        @(posedge i_clk);
        i_cmp_result <= 1'b0;
        i_touch_dout <= 1'b0;
        wr(4'h4, 8'h40);
        lk(2);
        chk({4'h0, o_pad_out[3:0]}, 8'h05);
        chk(o_pad_oe_n, 8'hF0);
        go(2'b00);
    endtask : t_hold

    task automatic t_sense();
        wr(4'h4, 8'h48);
        wr(4'h0, 8'h01);
        go(2'b10);
        chk({6'h00, o_pad_oe_n[7:6]}, 8'h00);
        chk({6'h00, o_pad_out[7:6]}, {6'h00, {2{~i_sense_clk}}});
        go(2'b00);
    endtask : t_sense

    task automatic t_wake();
        wr(4'h5, 8'h10);
        wr(4'h9, 8'h07);
        wr(4'h4, 8'h70);
        wr(4'h8, 8'h07);
        go(2'b10);
        @(posedge i_clk);
        drv_val <= 8'hB0;
        lk(6);
        chk(o_xint_in, 8'h10);
        chk({7'h00, o_irq}, 8'h01);
        wr(4'h8, 8'h01);
        wr(4'h9, 8'h06);
        drv_val <= 8'hA0;
        lk(6);
        rd(4'h7, 8'h01);
        chk({7'h00, o_irq}, 8'h00);
        wr(4'h8, 8'h01);
        i_cmp_analog <= 1'b1;
        lk(6);
        rd(4'h7, 8'h02);
        chk({7'h00, o_irq}, 8'h01);
        @(posedge i_clk);
        i_touch_det <= 1'b1;
        lk(6);
        rd(4'h7, 8'h06);
        wr(4'h8, 8'h06);
        rd(4'h7, 8'h00);
    endtask : t_wake

    task automatic t_rst_pin();
        @(posedge i_clk);
        i_rst_pad_n <= 1'b0;
        lk(5);
        chk({7'h00, o_ext_rst_req}, 8'h01);
        wr(4'h4, 8'h30);
        lk(4);
        chk({7'h00, o_ext_rst_req}, 8'h00);
    endtask : t_rst_pin

    initial
    begin
        t_reset();
        t_sleep();
        t_float();
        t_hold();
        t_sense();
        t_wake();
        t_rst_pin();
        print_verdict();
    end

    initial
    begin
        #100000;
        fails++;
        print_verdict();
    end
endmodule : testbench

bind pin_state_ctrl pin_state_properties chk_i (.i_clk, .i_rst, .i_ce,
    .i_addr, .i_wdata, .i_wr, .i_mode, .i_cmp_result, .i_sense_clk,
    .i_rst_pad_n, .o_pad_out, .o_pad_oe_n, .o_pad_ie, .o_pad_pu,
    .o_port_in, .o_ext_rst_req);

`default_nettype wire
